// >>> design/eep_consts.vh
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH
// apb byte offsets
`define EEP_OFS_STAT   8'h00
`define EEP_OFS_PIDX   8'h04
`define EEP_OFS_PWORD  8'h08
`define EEP_OFS_PFLASH_PROTECT_REG  8'h0C
`define EEP_OFS_EEPROT 8'h10
`define EEP_OFS_PSTAT  8'h14
`define EEP_OFS_CFG    8'h18
`define EEP_OFS_KEY    8'h1C
`define EEP_OFS_EERD   8'h20
// status register bit positions
`define EEP_B_CMD_COMPLETE_FLAG     7
`define EEP_B_ACCESS_ERROR_FLAG   5
`define EEP_B_PROTECT_VIOLATION_FLAG   4
`define EEP_B_MG1      1
`define EEP_B_MG0      0
// override selection bits
`define EEP_B_SEL_PF   0
`define EEP_B_SEL_EE   1
// eeprom protect layout
`define EEP_B_PROT_EN  7
// command opcodes
`define EEP_OP_PGM     8'h11
`define EEP_OP_ERS     8'h12
`define EEP_OP_OVR     8'h13
// launch index values
`define EEP_IDX_ONE    3'h1
`define EEP_IDX_TWO    3'h2
`define EEP_IDX_THREE  3'h3
`define EEP_IDX_FIVE   3'h5
// reset and erased values, eeprom base address
`define EEP_ERASED     16'hFFFF
`define EEP_KEY_RST    16'hFFFF
`define EEP_PFLASH_PROTECT_REG_RST  8'h00
`define EEP_EEPROT_RST 8'h00
`define EEP_EE_BASE    24'h100000
`endif

// >>> design/eep_seq.v
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "eep_consts.vh"
// Functional notes
// - opcode 0x11 programs one to four words
// - read back each programmed word afterwards
// - word1 low address, words2-5 carry data
// - index 010..101 sets count, else error
// - clearing complete flag launches; set when done
// - protected eeprom area sets violation, no write
// - odd byte address raises access error
// - span past eeprom end raises access error
// - address outside eeprom raises access error
// - command disallowed in mode raises error
// - verify errors set status bits one, zero
// - opcode 0x12 erases containing sector, verifies
// - erase needs index 001 at launch
// - override takes selection, key, two values
// - selection bits pick which protection loads
// - key match saves, loads, sets override bit
// - overridden protection values accepted freely
// - bad or erased key restores, clears override
// - erased stored key disables override until key rewritten
// - rejected override keeps protection registers
// - override needs index 001, 010, 011
// - restore without prior override is error
module eep_seq #(
   parameter EE_AW   = 5,
   parameter SECT_SH = 2
) (
   input  wire        CORE_CLK,
   input  wire        RESET_N,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR
);

////////////////////////////////////////////////////////////////
// constants

// machine states
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_CHK  = 3'h1;
localparam [2:0] S_PGM  = 3'h2;
localparam [2:0] S_VFY  = 3'h3;
localparam [2:0] S_DONE = 3'h4;
// eeprom geometry
localparam        EE_WORDS = 1 << EE_AW;
localparam [23:0] EE_BYTES = 24'h2 << EE_AW;
localparam [EE_AW:0] SECT_N = {{EE_AW{1'b0}}, 1'b1} << SECT_SH;

////////////////////////////////////////////////////////////////
// state

// status flags
reg               cmd_complete_flag;
reg               access_error_flag;
reg               protect_violation_flag;
reg               verify_status_bit1;
reg               verify_status_bit0;
// parameter storage
reg  [2:0]        param_index;
reg  [15:0]       cmd_param_word [0:5];
// protection and override
reg  [7:0]        pflash_protect_reg;
reg  [7:0]        eeprom_protect_reg;
reg  [7:0]        pf_saved;
reg  [7:0]        ee_saved;
reg               override_active_bit;
// configuration
reg               mode_ok;
reg  [15:0]       cfg_key;
reg  [EE_AW-1:0]  rd_idx;
// sequencer
reg  [2:0]        state;
reg  [7:0]        op;
reg  [2:0]        l_idx;
reg  [EE_AW-1:0]  wbase;
reg  [EE_AW:0]    wcnt;
reg  [EE_AW:0]    pos;
// eeprom array
reg  [15:0]       ee_mem [0:EE_WORDS-1];
integer           k;

////////////////////////////////////////////////////////////////
// apb decode

// access phase strobes
wire acc    = PSEL & PENABLE;
wire wr_acc = acc & PWRITE;
// address hit
reg  hit;
always @* begin
   case (PADDR)
      `EEP_OFS_STAT, `EEP_OFS_PIDX, `EEP_OFS_PWORD,
      `EEP_OFS_PFLASH_PROTECT_REG, `EEP_OFS_EEPROT, `EEP_OFS_PSTAT,
      `EEP_OFS_CFG, `EEP_OFS_KEY, `EEP_OFS_EERD: hit = 1'b1;
      default: hit = 1'b0;
   endcase
end

// zero wait states, error on unmapped
assign PREADY  = 1'b1;
assign PSLVERR = acc & ~hit;

// register write strobes
wire wr_ok   = wr_acc & hit;
wire wr_stat = wr_ok & (PADDR == `EEP_OFS_STAT);
// writes to parameters only while idle
wire wr_idle = wr_ok & cmd_complete_flag;

wire launch = wr_stat & PWDATA[`EEP_B_CMD_COMPLETE_FLAG] & cmd_complete_flag
              & ~access_error_flag & ~protect_violation_flag;

////////////////////////////////////////////////////////////////
// read mux

// selected parameter word
wire [15:0] pword = (param_index > `EEP_IDX_FIVE) ? 16'h0000
                    : cmd_param_word[param_index];
reg  [31:0] rd_data;
always @* begin
   rd_data = 32'h00000000;
   case (PADDR)
      `EEP_OFS_STAT: begin
         rd_data[`EEP_B_CMD_COMPLETE_FLAG]   = cmd_complete_flag;
         rd_data[`EEP_B_ACCESS_ERROR_FLAG] = access_error_flag;
         rd_data[`EEP_B_PROTECT_VIOLATION_FLAG] = protect_violation_flag;
         rd_data[`EEP_B_MG1]    = verify_status_bit1;
         rd_data[`EEP_B_MG0]    = verify_status_bit0;
      end
      `EEP_OFS_PIDX:   rd_data[2:0]  = param_index;
      `EEP_OFS_PWORD:  rd_data[15:0] = pword;
      `EEP_OFS_PFLASH_PROTECT_REG:  rd_data[7:0]  = pflash_protect_reg;
      `EEP_OFS_EEPROT: rd_data[7:0]  = eeprom_protect_reg;
      `EEP_OFS_PSTAT:  rd_data[0]    = override_active_bit;
      `EEP_OFS_CFG:    rd_data[0]    = mode_ok;
      `EEP_OFS_KEY:    rd_data[15:0] = cfg_key;
      `EEP_OFS_EERD: begin
         rd_data[15:0]        = ee_mem[rd_idx];
         rd_data[16+EE_AW-1:16] = rd_idx;
      end
      default: rd_data = 32'h00000000;
   endcase
end

// read data captured in setup phase
always @(posedge CORE_CLK or negedge RESET_N) begin
   if (!RESET_N) begin
      PRDATA <= 32'h00000000;
   end else if (PSEL & ~PENABLE & ~PWRITE) begin
      PRDATA <= rd_data;
   end
end

////////////////////////////////////////////////////////////////
// address checks

// address from words zero and one
wire [23:0] gaddr = {cmd_param_word[0][7:0], cmd_param_word[1]};
wire [23:0] off   = gaddr - `EEP_EE_BASE;
wire in_rng = (gaddr >= `EEP_EE_BASE) & (off < EE_BYTES);
wire odd    = gaddr[0];
wire [2:0]  pcnt = l_idx - 3'h1;
wire [23:0] end_off = off + {20'h00000, pcnt, 1'b0} - 24'h1;
wire breach = end_off >= EE_BYTES;
// first word index
wire [EE_AW-1:0] widx = off[EE_AW:1];
wire [EE_AW-1:0] sbase = (widx >> SECT_SH) << SECT_SH;
// last word touched by each command
wire [EE_AW-1:0] plast = widx + {{(EE_AW-3){1'b0}}, pcnt} - 1'b1;
wire [EE_AW-1:0] slast = sbase + SECT_N[EE_AW-1:0] - 1'b1;
wire [EE_AW-1:0] last  = (op == `EEP_OP_ERS) ? slast : plast;
wire [EE_AW-1:0] lsec  = last >> SECT_SH;
// protected when last sector at or above limit
wire prot_hit = eeprom_protect_reg[`EEP_B_PROT_EN]
                & ({1'b0, lsec} >= {1'b0, eeprom_protect_reg[6:0]});

// program error set
wire pgm_err = ~mode_ok | (l_idx < `EEP_IDX_TWO)
               | (l_idx > `EEP_IDX_FIVE) | ~in_rng | odd | breach;
wire ers_err = ~mode_ok | (l_idx != `EEP_IDX_ONE) | ~in_rng | odd;

////////////////////////////////////////////////////////////////
// override checks

// selection and key
wire [1:0]  sel = cmd_param_word[0][1:0];
wire [15:0] key = cmd_param_word[1];
wire key_ok = (key == cfg_key) & (cfg_key != `EEP_KEY_RST)
              & (key != `EEP_ERASED);
wire ovr_idx = (l_idx == `EEP_IDX_ONE) | (l_idx == `EEP_IDX_TWO)
               | (l_idx == `EEP_IDX_THREE);
// selection needs loaded values
wire ovr_sel = (sel == 2'h0) & (key_ok | (l_idx != `EEP_IDX_ONE));
wire ovr_nors = ~key_ok & ~override_active_bit;
wire ovr_err = ~mode_ok | ~ovr_idx | ovr_sel | ovr_nors;

////////////////////////////////////////////////////////////////
// verify compare

// current word and expected value
wire [EE_AW-1:0] cur = wbase + pos[EE_AW-1:0];
wire [2:0]       dix = pos[2:0] + 3'h2;
wire [15:0] expv = (op == `EEP_OP_ERS) ? `EEP_ERASED
                   : cmd_param_word[dix];
wire mism = ee_mem[cur] != expv;

////////////////////////////////////////////////////////////////
// sequencer, registers and array

always @(posedge CORE_CLK or negedge RESET_N) begin
   if (!RESET_N) begin
      cmd_complete_flag      <= 1'b1;
      access_error_flag      <= 1'b0;
      protect_violation_flag <= 1'b0;
      verify_status_bit1     <= 1'b0;
      verify_status_bit0     <= 1'b0;
      param_index            <= 3'h0;
      for (k = 0; k < 6; k = k + 1) begin
         cmd_param_word[k] <= 16'h0000;
      end
      pflash_protect_reg  <= `EEP_PFLASH_PROTECT_REG_RST;
      eeprom_protect_reg  <= `EEP_EEPROT_RST;
      pf_saved            <= 8'h00;
      ee_saved            <= 8'h00;
      override_active_bit <= 1'b0;
      mode_ok             <= 1'b1;
      cfg_key             <= `EEP_KEY_RST;
      rd_idx              <= {EE_AW{1'b0}};
      state               <= S_IDLE;
      op                  <= 8'h00;
      l_idx               <= 3'h0;
      wbase               <= {EE_AW{1'b0}};
      wcnt                <= {(EE_AW+1){1'b0}};
      pos                 <= {(EE_AW+1){1'b0}};
      for (k = 0; k < EE_WORDS; k = k + 1) begin
         ee_mem[k] <= `EEP_ERASED;
      end
   end else begin
      // software clears first, hardware sets below win
      if (wr_stat & PWDATA[`EEP_B_ACCESS_ERROR_FLAG]) begin
         access_error_flag <= 1'b0;
      end
      if (wr_stat & PWDATA[`EEP_B_PROTECT_VIOLATION_FLAG]) begin
         protect_violation_flag <= 1'b0;
      end
      // configuration writes
      if (wr_ok & (PADDR == `EEP_OFS_CFG)) begin
         mode_ok <= PWDATA[0];
      end
      if (wr_ok & (PADDR == `EEP_OFS_KEY)) begin
         cfg_key <= PWDATA[15:0];
      end
      if (wr_ok & (PADDR == `EEP_OFS_EERD)) begin
         rd_idx <= PWDATA[EE_AW-1:0];
      end
      // parameter loading while idle
      if (wr_idle & (PADDR == `EEP_OFS_PIDX)) begin
         param_index <= PWDATA[2:0];
      end
      if (wr_idle & (PADDR == `EEP_OFS_PWORD)
          & (param_index <= `EEP_IDX_FIVE)) begin
         cmd_param_word[param_index] <= PWDATA[15:0];
      end
      // direct protection writes while idle
      if (wr_idle & (PADDR == `EEP_OFS_PFLASH_PROTECT_REG)) begin
         pflash_protect_reg <= PWDATA[7:0];
      end
      if (wr_idle & (PADDR == `EEP_OFS_EEPROT)) begin
         eeprom_protect_reg <= PWDATA[7:0];
      end
      case (state)
         // wait for launch
         S_IDLE: begin
            if (launch) begin
               cmd_complete_flag  <= 1'b0;
               verify_status_bit1 <= 1'b0;
               verify_status_bit0 <= 1'b0;
               op                 <= cmd_param_word[0][15:8];
               l_idx              <= param_index;
               state              <= S_CHK;
            end
         end
         // launch checks per opcode
         S_CHK: begin
            state <= S_DONE;
            pos   <= {(EE_AW+1){1'b0}};
            case (op)
               `EEP_OP_PGM: begin
                  if (pgm_err) begin
                     access_error_flag <= 1'b1;
                  end else if (prot_hit) begin
                     protect_violation_flag <= 1'b1;
                  end else begin
                     wbase <= widx;
                     wcnt  <= {{(EE_AW-2){1'b0}}, pcnt};
                     state <= S_PGM;
                  end
               end
               `EEP_OP_ERS: begin
                  if (ers_err) begin
                     access_error_flag <= 1'b1;
                  end else if (prot_hit) begin
                     protect_violation_flag <= 1'b1;
                  end else begin
                     wbase <= sbase;
                     wcnt  <= SECT_N;
                     state <= S_PGM;
                  end
               end
               `EEP_OP_OVR: begin
                  if (ovr_err) begin
                     access_error_flag <= 1'b1;
                  end else if (key_ok) begin
                     pf_saved            <= pflash_protect_reg;
                     ee_saved            <= eeprom_protect_reg;
                     override_active_bit <= 1'b1;
                     if (sel[`EEP_B_SEL_PF]) begin
                        pflash_protect_reg <= cmd_param_word[2][7:0];
                     end
                     if (sel[`EEP_B_SEL_EE]) begin
                        eeprom_protect_reg <= cmd_param_word[3][7:0];
                     end
                  end else begin
                     pflash_protect_reg  <= pf_saved;
                     eeprom_protect_reg  <= ee_saved;
                     override_active_bit <= 1'b0;
                  end
               end
               // unknown opcode
               default: access_error_flag <= 1'b1;
            endcase
         end
         // one word per cycle; program bits only clear, erase sets all
         S_PGM: begin
            if (op == `EEP_OP_ERS) begin
               ee_mem[cur] <= `EEP_ERASED;
            end else begin
               ee_mem[cur] <= ee_mem[cur] & cmd_param_word[dix];
            end
            if (pos == wcnt - 1'b1) begin
               pos   <= {(EE_AW+1){1'b0}};
               state <= S_VFY;
            end else begin
               pos <= pos + 1'b1;
            end
         end
         S_VFY: begin
            if (mism) begin
               verify_status_bit1 <= 1'b1;
               verify_status_bit0 <= 1'b1;
            end
            if (pos == wcnt - 1'b1) begin
               state <= S_DONE;
            end else begin
               pos <= pos + 1'b1;
            end
         end
         S_DONE: begin
            cmd_complete_flag <= 1'b1;
            state             <= S_IDLE;
         end
         default: state <= S_IDLE;
      endcase
   end
end

endmodule

// >>> dv/eep_seq_checker.sv
`timescale 1ns/100ps
`include "eep_consts.vh"
module eep_seq_checker #(
   parameter EE_AW   = 5,
   parameter SECT_SH = 2
) (
   input wire        CORE_CLK,
   input wire        RESET_N,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [7:0]  PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR
);
   // access phase and read access
   wire acc = PSEL & PENABLE;
   wire rd  = acc & ~PWRITE;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////////////////
   property p_ready;
      PSEL |-> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("ready low in transfer");
   property p_stat;
      rd && PADDR == `EEP_OFS_STAT |-> (PRDATA & 32'hFFFFFF4C) == 32'h0;
   endproperty
   a_stat: assert property (p_stat) else $error("status spare bits set");
   property p_pidx;
      rd && PADDR == `EEP_OFS_PIDX |-> PRDATA[31:3] == 29'h0;
   endproperty
   a_pidx: assert property (p_pidx) else $error("index spare bits set");
   property p_pword;
      rd && PADDR == `EEP_OFS_PWORD |-> PRDATA[31:16] == 16'h0;
   endproperty
   a_pword: assert property (p_pword) else $error("param word wider than 16");
   property p_pstat;
      rd && PADDR == `EEP_OFS_PSTAT |-> PRDATA[31:1] == 31'h0;
   endproperty
   a_pstat: assert property (p_pstat) else $error("override status spare set");
   property p_key;
      rd && PADDR == `EEP_OFS_KEY |-> PRDATA[31:16] == 16'h0;
   endproperty
   a_key: assert property (p_key) else $error("key wider than 16");
   property p_eerd;
      rd && PADDR == `EEP_OFS_EERD |-> (PRDATA >> (16 + EE_AW)) == 32'h0;
   endproperty
   a_eerd: assert property (p_eerd) else $error("readback spare bits set");
   property p_unmap;
      acc && PADDR > `EEP_OFS_EERD |-> PSLVERR && (PWRITE || PRDATA == 32'h0);
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
   property p_mapped;
      acc && PADDR <= `EEP_OFS_EERD && PADDR[1:0] == 2'h0 |-> !PSLVERR;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_hold;
      !$past(PSEL && !PENABLE && !PWRITE) |-> $stable(PRDATA);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind eep_seq eep_seq_checker #(.EE_AW(EE_AW), .SECT_SH(SECT_SH)) u_chk (
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR));

// >>> dv/tb_eeprom_program_erase_protect_override.sv
`timescale 1ns/100ps
`include "eep_consts.vh"
module tb_eeprom_program_erase_protect_override;
   reg         clk;
   reg         rst_n;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   integer     errors;
   integer     num_checks;
   reg  [31:0] rv;
   reg         se;
   // block under test, small eeprom
   eep_seq #(.EE_AW(5), .SECT_SH(2)) DUT (
      .CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr));
   // 40 mhz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task test_done;
      begin
         $display("checks %0d mismatches %0d", num_checks, errors);
         if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask
   // compare seen against expected
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // one apb transfer, read data and error taken at ready edge
   task xfer(input w, input [7:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1) @(posedge clk);
         rv = prdata;
         se = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask
   // register read and compare
   task rg(input string nm, input [7:0] a, input [31:0] e);
      begin
         xfer(1'b0, a, 32'h0);
         chk(nm, rv, e);
      end
   endtask
   // eeprom word readback
   task ee(input [4:0] w, input [15:0] e);
      begin
         xfer(1'b1, `EEP_OFS_EERD, {27'h0, w});
         rg("eeword", `EEP_OFS_EERD, {11'h000, w, e});
      end
   endtask
   // load six words, launch, poll, check status, clear errors
   task cmd(input [95:0] w, input [2:0] n, input [31:0] e);
      integer k;
      begin
         for (k = 0; k < 6; k = k + 1) begin
            xfer(1'b1, `EEP_OFS_PIDX, k);
            xfer(1'b1, `EEP_OFS_PWORD, {16'h0000, w[95-16*k -: 16]});
         end
         xfer(1'b1, `EEP_OFS_PIDX, {29'h0, n});
         xfer(1'b1, `EEP_OFS_STAT, 32'h80);
         k = 0;
         rv = 32'h0;
         while (rv[7] !== 1'b1 && k < 100) begin
            xfer(1'b0, `EEP_OFS_STAT, 32'h0);
            k = k + 1;
         end
         chk("status", rv, e);
         xfer(1'b1, `EEP_OFS_STAT, 32'h30);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      errors = errors + 1;
      test_done;
   end
   // main sequence
   initial begin
      errors = 0;
      num_checks = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rg("stat", `EEP_OFS_STAT, 32'h80);
      rg("cfg", `EEP_OFS_CFG, 32'h1);
      rg("key", `EEP_OFS_KEY, 32'hFFFF);
      $display("reset test done");
      cmd({16'h1110, 16'h0000, 16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0}, 3'h5, 32'h80);
      ee(5'h00, 16'h1234);
      ee(5'h01, 16'h5678);
      ee(5'h02, 16'h9ABC);
      ee(5'h03, 16'hDEF0);
      cmd({16'h1110, 16'h0008, 64'h0}, 3'h1, 32'hA0);
      cmd({16'h1110, 16'h0008, 64'h0}, 3'h6, 32'hA0);
      cmd({16'h1110, 16'h0009, 64'h0}, 3'h2, 32'hA0);
      cmd({16'h1110, 16'h003E, 64'h0}, 3'h3, 32'hA0);
      cmd({16'h1120, 16'h0000, 64'h0}, 3'h2, 32'hA0);
      xfer(1'b1, `EEP_OFS_CFG, 32'h0);
      cmd({16'h1110, 16'h0010, 64'h0}, 3'h2, 32'hA0);
      xfer(1'b1, `EEP_OFS_CFG, 32'h1);
      cmd({16'h1110, 16'h0000, 16'hFFFF, 48'h0}, 3'h2, 32'h83);
      $display("program test done");
      cmd({16'h1210, 16'h0006, 64'h0}, 3'h1, 32'h80);
      ee(5'h00, 16'hFFFF);
      ee(5'h03, 16'hFFFF);
      cmd({16'h1110, 16'h0002, 16'hA5A5, 48'h0}, 3'h2, 32'h80);
      ee(5'h01, 16'hA5A5);
      cmd({16'h1210, 16'h0006, 64'h0}, 3'h2, 32'hA0);
      xfer(1'b1, `EEP_OFS_EEPROT, 32'h80);
      cmd({16'h1110, 16'h0000, 16'h0F0F, 48'h0}, 3'h2, 32'h90);
      ee(5'h00, 16'hFFFF);
      cmd({16'h1210, 16'h0000, 64'h0}, 3'h1, 32'h90);
      $display("erase test done");
      cmd({16'h1303, 16'hFFFF, 16'h0011, 48'h0}, 3'h3, 32'hA0);
      rg("pflash_protect_reg", `EEP_OFS_PFLASH_PROTECT_REG, 32'h0);
      xfer(1'b1, `EEP_OFS_KEY, 32'h5A5A);
      cmd({16'h1301, 16'h5A5A, 16'h0022, 48'h0}, 3'h2, 32'h80);
      rg("pflash_protect_reg", `EEP_OFS_PFLASH_PROTECT_REG, 32'h22);
      rg("eeprot", `EEP_OFS_EEPROT, 32'h80);
      rg("pstat", `EEP_OFS_PSTAT, 32'h1);
      cmd({16'h1303, 16'h5A5A, 16'h0033, 16'h0000, 32'h0}, 3'h3, 32'h80);
      rg("pflash_protect_reg", `EEP_OFS_PFLASH_PROTECT_REG, 32'h33);
      rg("eeprot", `EEP_OFS_EEPROT, 32'h0);
      cmd({16'h1301, 16'h5A5A, 16'h0044, 16'h0044, 32'h0}, 3'h4, 32'hA0);
      rg("pflash_protect_reg", `EEP_OFS_PFLASH_PROTECT_REG, 32'h33);
      cmd({16'h1301, 16'h1111, 64'h0}, 3'h2, 32'h80);
      rg("pflash_protect_reg", `EEP_OFS_PFLASH_PROTECT_REG, 32'h22);
      rg("eeprot", `EEP_OFS_EEPROT, 32'h80);
      rg("pstat", `EEP_OFS_PSTAT, 32'h0);
      cmd({16'h1301, 16'hFFFF, 64'h0}, 3'h2, 32'hA0);
      rg("pidx", `EEP_OFS_PIDX, 32'h2);
      xfer(1'b1, `EEP_OFS_PIDX, 32'h1);
      rg("pword", `EEP_OFS_PWORD, 32'hFFFF);
      $display("override test done");
      xfer(1'b0, 8'h24, 32'h0);
      chk("slverr", {31'h0, se}, 32'h1);
      chk("unmapped", rv, 32'h0);
      $display("bus test done");
      test_done;
   end
endmodule
